//--- src/sdh_regs.svh
// Widths, reset values and idle pin levels for the storage card DMA/IO handshake
`ifndef SDH_REGS_SVH
`define SDH_REGS_SVH
`define SDH_DATA_W 16
`define SDH_PIN_W 8
`define SDH_SYNC_W 24
`define SDH_PIN_RST 8'hF3
`define SDH_DATA_RST 16'h0000
`define SDH_BIT_RST 1'h0
`define SDH_BIT_SET 1'h1
`endif

//--- src/sdh_pkg.sv
// Types shared by the storage card DMA/IO handshake block
`include "sdh_regs.svh"
package sdh_pkg;
  typedef enum logic [1:0] {
    SDH_MODE_MEMORY,
    SDH_MODE_IO,
    SDH_MODE_IDE
  } sdh_mode_t;

  typedef enum logic [1:0] {
    SDH_REQ_IDLE,
    SDH_REQ_ASSERT,
    SDH_REQ_RELEASE
  } sdh_req_state_t;

  // Host pins, raw or synchronised; bit order matches `SDH_PIN_RST
  typedef struct packed {
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic dma_ack_n;
    logic host_dma_ready_n;
    logic host_data_strobe;
    logic stop;
    logic card_enable_low_n;
    logic card_enable_high_n;
  } sdh_pins_t;
endpackage

//--- src/sdh_pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/10ps
`include "sdh_regs.svh"
module sdh_pin_sync #(
  parameter int WIDTH = `SDH_SYNC_W,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] stable_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1, s2, s3, q;
      logic next_s1, next_s2, next_s3, next_q;
      always_comb begin
        next_s1 = s1;
        next_s2 = s2;
        next_s3 = s3;
        next_q = q;
        if (ce_in) begin
          next_s1 = async_in[i];
          next_s2 = s1;
          next_s3 = s2;
          // Single-stage glitches never reach the filtered value
          if (s2 == s3) begin
            next_q = s3;
          end
        end
      end
      always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
          s1 <= RST_VAL[i];
          s2 <= RST_VAL[i];
          s3 <= RST_VAL[i];
          q <= RST_VAL[i];
        end else begin
          s1 <= next_s1;
          s2 <= next_s2;
          s3 <= next_s3;
          q <= next_q;
        end
      end
      assign stable_out[i] = q;
    end
  endgenerate
endmodule

//--- src/sdh_dma_io.sv
// Card-side DMA request, I/O read and Ultra DMA strobe handshake logic
//
// Operation
// R1: I/O mode, no Ultra DMA: input ack low while selected and answering read.
// R2: Single-socket hosts may ignore input ack, using card enables instead.
// R3: Card asserts DMA request when ready to move data.
// R4: Request held until ack, then negated, reasserted if more data.
// R5: Host sets multiword DMA direction with I/O read or write strobe.
// R6: Host ignores request during I/O reads and avoids reads while requested.
// R7: IDE mode: request undriven unless drive-select picks this device.
// R8: Host keeps selects negated during DMA; transfers are 16 bits.
// R9: I/O mode: read data driven only while I/O read strobe asserted.
// R10: IDE mode without Ultra DMA: I/O read strobe as in I/O mode.
// R11: Host DMA-ready shows it accepts Ultra DMA data-in; negation pauses.
// R12: Ultra DMA write captures a word on both host strobe edges.
// R13: Host pauses data-out by not toggling strobe; card just waits.
// R14: Stop asserted during Ultra DMA ends the current burst.
// R15: Request active low in card modes, active high in IDE mode.
`timescale 1ns/10ps
`include "sdh_regs.svh"
module sdh_dma_io (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire sdh_pkg::sdh_mode_t mode_strap_in,
  input wire sdh_pkg::sdh_pins_t pins_in,
  input wire logic [`SDH_DATA_W-1:0] data_pins_in,
  input wire logic io_addr_hit_in,
  input wire logic [`SDH_DATA_W-1:0] io_read_data_in,
  input wire logic drive_selected_in,
  input wire logic xfer_pending_in,
  input wire logic udma_active_in,
  input wire logic udma_write_in,
  output logic dma_request_out,
  output logic dma_request_oe_out,
  output logic input_ack_n_out,
  output logic [`SDH_DATA_W-1:0] data_out,
  output logic data_oe_out,
  output logic [`SDH_DATA_W-1:0] rx_word_out,
  output logic rx_valid_out,
  output logic burst_stop_out,
  output logic host_ready_out,
  output logic mdma_to_host_out,
  output sdh_pkg::sdh_mode_t mode_out
);
  logic [`SDH_SYNC_W-1:0] sync_q;
  sdh_pkg::sdh_pins_t pin;
  logic [`SDH_DATA_W-1:0] pin_data;

  sdh_pin_sync #(
    .WIDTH(`SDH_SYNC_W),
    .RST_VAL({`SDH_PIN_RST, `SDH_DATA_RST})
  ) u_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .ce_in(ce_in),
    .async_in({pins_in, data_pins_in}),
    .stable_out(sync_q)
  );

  assign pin = sdh_pkg::sdh_pins_t'(sync_q[`SDH_SYNC_W-1:`SDH_DATA_W]);
  // Data rides the strobe's chain, so a captured word lines up with its edge
  assign pin_data = sync_q[`SDH_DATA_W-1:0];

  // Registered state
  logic mode_valid;
  sdh_pkg::sdh_mode_t mode;
  sdh_pkg::sdh_req_state_t req_state;
  logic prev_strobe;
  logic prev_stop;

  logic next_mode_valid;
  sdh_pkg::sdh_mode_t next_mode;
  sdh_pkg::sdh_req_state_t next_req_state;
  logic next_prev_strobe;
  logic next_prev_stop;
  logic next_dma_request;
  logic next_dma_request_oe;
  logic next_input_ack_n;
  logic [`SDH_DATA_W-1:0] next_data;
  logic next_data_oe;
  logic [`SDH_DATA_W-1:0] next_rx_word;
  logic next_rx_valid;
  logic next_burst_stop;
  logic next_host_ready;
  logic next_mdma_to_host;

  // Decoded conditions
  logic selected;
  logic ack;
  logic io_read_active;
  logic req_active;
  logic udma_out_burst;

  always_comb begin
    selected = !pin.card_enable_low_n || !pin.card_enable_high_n;
    ack = !pin.dma_ack_n;
    // IDE mode drives I/O read data like I/O mode outside Ultra DMA; input ack stays I/O-only
    io_read_active = (mode == sdh_pkg::SDH_MODE_IO || mode == sdh_pkg::SDH_MODE_IDE) && mode_valid
                     && !udma_active_in && selected && !pin.io_read_strobe_n; // R9 R10
    udma_out_burst = udma_active_in && udma_write_in && ack;

    next_mode_valid = mode_valid;
    next_mode = mode;
    next_req_state = req_state;
    next_prev_strobe = prev_strobe;
    next_prev_stop = prev_stop;
    next_dma_request = dma_request_out;
    next_dma_request_oe = dma_request_oe_out;
    next_input_ack_n = input_ack_n_out;
    next_data = data_out;
    next_data_oe = data_oe_out;
    next_rx_word = rx_word_out;
    next_rx_valid = rx_valid_out;
    next_burst_stop = burst_stop_out;
    next_host_ready = host_ready_out;
    next_mdma_to_host = mdma_to_host_out;
    req_active = `SDH_BIT_RST;

    if (ce_in) begin
      // Strap caught once, on the first enabled cycle after reset release
      if (!mode_valid) begin
        next_mode = mode_strap_in;
        next_mode_valid = `SDH_BIT_SET;
      end

      case (req_state)
        sdh_pkg::SDH_REQ_IDLE: begin
          if (xfer_pending_in && mode_valid && !ack) begin
            next_req_state = sdh_pkg::SDH_REQ_ASSERT; // R3
          end
        end
        sdh_pkg::SDH_REQ_ASSERT: begin
          // Held until the host acknowledges
          if (ack) begin
            next_req_state = sdh_pkg::SDH_REQ_RELEASE; // R4
          end
        end
        sdh_pkg::SDH_REQ_RELEASE: begin
          // Rearm only after ack drops so one ack never counts twice
          if (!ack) begin
            next_req_state = sdh_pkg::SDH_REQ_IDLE; // R4
          end
        end
        default: begin
          next_req_state = sdh_pkg::SDH_REQ_IDLE;
        end
      endcase
      req_active = (next_req_state == sdh_pkg::SDH_REQ_ASSERT);

      // Mode being latched, not the old one: no wrong-polarity request pulse after reset
      next_dma_request = (next_mode == sdh_pkg::SDH_MODE_IDE) ? req_active : !req_active; // R15
      next_dma_request_oe = (next_mode != sdh_pkg::SDH_MODE_IDE) || drive_selected_in; // R7

      // Input ack only for hits in I/O mode; IDE and memory never raise it
      next_input_ack_n = !(mode == sdh_pkg::SDH_MODE_IO && io_read_active && io_addr_hit_in); // R1
      next_data_oe = io_read_active; // R9 R10
      next_data = io_read_active ? io_read_data_in : `SDH_DATA_RST;

      // Both strobe edges land a word; no edge, no capture
      next_prev_strobe = pin.host_data_strobe;
      next_rx_valid = udma_out_burst && !pin.stop && (pin.host_data_strobe != prev_strobe); // R12 R13
      if (next_rx_valid) begin
        next_rx_word = pin_data; // R12
      end

      next_prev_stop = pin.stop;
      next_burst_stop = udma_active_in && pin.stop && !prev_stop; // R14
      next_host_ready = udma_active_in && !udma_write_in && !pin.host_dma_ready_n; // R11

      // Direction follows whichever strobe the host pulses under ack
      if (ack && !udma_active_in) begin
        if (!pin.io_read_strobe_n) begin
          next_mdma_to_host = `SDH_BIT_SET; // R5
        end else if (!pin.io_write_strobe_n) begin
          next_mdma_to_host = `SDH_BIT_RST; // R5
        end
      end
    end
  end

  // All pin outputs registered so decode glitches never reach the host
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mode_valid <= `SDH_BIT_RST;
      mode <= sdh_pkg::SDH_MODE_MEMORY;
      req_state <= sdh_pkg::SDH_REQ_IDLE;
      prev_strobe <= `SDH_BIT_RST;
      prev_stop <= `SDH_BIT_RST;
      dma_request_out <= `SDH_BIT_SET;
      dma_request_oe_out <= `SDH_BIT_RST;
      input_ack_n_out <= `SDH_BIT_SET;
      data_out <= `SDH_DATA_RST;
      data_oe_out <= `SDH_BIT_RST;
      rx_word_out <= `SDH_DATA_RST;
      rx_valid_out <= `SDH_BIT_RST;
      burst_stop_out <= `SDH_BIT_RST;
      host_ready_out <= `SDH_BIT_RST;
      mdma_to_host_out <= `SDH_BIT_RST;
    end else begin
      mode_valid <= next_mode_valid;
      mode <= next_mode;
      req_state <= next_req_state;
      prev_strobe <= next_prev_strobe;
      prev_stop <= next_prev_stop;
      dma_request_out <= next_dma_request;
      dma_request_oe_out <= next_dma_request_oe;
      input_ack_n_out <= next_input_ack_n;
      data_out <= next_data;
      data_oe_out <= next_data_oe;
      rx_word_out <= next_rx_word;
      rx_valid_out <= next_rx_valid;
      burst_stop_out <= next_burst_stop;
      host_ready_out <= next_host_ready;
      mdma_to_host_out <= next_mdma_to_host;
    end
  end

  assign mode_out = mode;
endmodule

//--- tb/sdh_dma_io_props.sv
// Port-level assertions for the DMA/IO handshake block
`timescale 1ns/10ps
module sdh_dma_io_props (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire sdh_pkg::sdh_pins_t pins_in,
  input wire logic io_addr_hit_in,
  input wire logic drive_selected_in,
  input wire logic xfer_pending_in,
  input wire logic udma_active_in,
  input wire logic udma_write_in,
  input wire logic dma_request_out,
  input wire logic input_ack_n_out,
  input wire logic dma_request_oe_out,
  input wire logic [15:0] data_out,
  input wire logic data_oe_out,
  input wire logic rx_valid_out,
  input wire logic burst_stop_out,
  input wire logic host_ready_out,
  input wire sdh_pkg::sdh_mode_t mode_out
);
  logic ide;
  logic req_on;
  assign ide = mode_out == sdh_pkg::SDH_MODE_IDE;
  assign req_on = ide ? dma_request_out : !dma_request_out;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // Third-edge guard: polarity settles on the first edge after release
  req_cause_a: assert property ($rose(req_on) && $past(reset_n_in, 3) |-> $past(xfer_pending_in))
    else $error("request rose with nothing pending");
  req_held_a: assert property ($fell(req_on) && $past(reset_n_in, 3) |-> !$past(pins_in.dma_ack_n, 4))
    else $error("request dropped without acknowledge");
  req_drop_a: assert property ((!pins_in.dma_ack_n) [*8] |-> !req_on)
    else $error("request still active under acknowledge");
  oe_select_a: assert property (ide && !drive_selected_in |=> !dma_request_oe_out)
    else $error("request driven while not selected");
  mem_quiet_a: assert property (mode_out == sdh_pkg::SDH_MODE_MEMORY |-> !data_oe_out && input_ack_n_out)
    else $error("memory mode drove an I/O output");
  ack_hit_a: assert property (!input_ack_n_out |-> data_oe_out && !ide && $past(io_addr_hit_in))
    else $error("input ack without a hit read");
  udma_no_oe_a: assert property (udma_active_in |=> !data_oe_out)
    else $error("read data driven during Ultra DMA");
  rx_source_a: assert property (rx_valid_out |-> $past(udma_active_in && udma_write_in))
    else $error("word captured outside a data-out burst");
  stop_pulse_a: assert property (burst_stop_out |-> $past(udma_active_in) ##1 !burst_stop_out)
    else $error("stop pulse wrong");
  ready_src_a: assert property (host_ready_out |-> $past(udma_active_in && !udma_write_in))
    else $error("host ready outside data-in");
  cover property (rx_valid_out);
  cover property (burst_stop_out);
  cover property (!input_ack_n_out);
endmodule
bind sdh_dma_io sdh_dma_io_props i_sdh_dma_io_props (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
  .pins_in(pins_in), .io_addr_hit_in(io_addr_hit_in), .drive_selected_in(drive_selected_in),
  .xfer_pending_in(xfer_pending_in), .udma_active_in(udma_active_in), .udma_write_in(udma_write_in),
  .dma_request_out(dma_request_out), .input_ack_n_out(input_ack_n_out), .dma_request_oe_out(dma_request_oe_out),
  .data_out(data_out), .data_oe_out(data_oe_out), .rx_valid_out(rx_valid_out), .burst_stop_out(burst_stop_out),
  .host_ready_out(host_ready_out), .mode_out(mode_out));

//--- tb/sdh_host_model.sv
// Host-side model answering the card's DMA request
`timescale 1ns/10ps
module sdh_host_model (
  input wire logic clk_in,
  input wire logic req_on_in,
  input wire logic slow_in,
  input wire logic hold_in,
  output logic ack_n_out,
  output logic [7:0] acks_out
);
  logic [3:0] wait_cnt = 4'h0;
  initial ack_n_out = 1'h1;
  initial acks_out = 8'h00;
  always @(negedge clk_in) begin
    if (hold_in) begin
      ack_n_out <= 1'h0;
    end else if (ack_n_out && req_on_in) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (!slow_in || wait_cnt == 4'hF) begin
        ack_n_out <= 1'h0;
        acks_out <= acks_out + 8'h01;
        wait_cnt <= 4'h0;
      end
    end else if (!req_on_in) begin
      ack_n_out <= 1'h1;
    end
  end
endmodule

//--- tb/sdh_dma_io_tb.sv
// Self-checking bench for the DMA/IO handshake block
`timescale 1ns/10ps
module sdh_dma_io_tb;
  logic core_clk_in = 0, reset_n_in = 0, ce_in = 1;
  sdh_pkg::sdh_mode_t mode_strap_in = sdh_pkg::SDH_MODE_MEMORY, mode_out;
  sdh_pkg::sdh_pins_t pins_in;
  logic [7:0] pv = 8'hF3, acks, a0;
  logic [15:0] data_pins_in = 0, io_read_data_in = 0, data_out, rx_word_out, wq[$];
  logic io_addr_hit_in = 0, drive_selected_in = 0, xfer_pending_in = 0, udma_active_in = 0, udma_write_in = 0;
  logic dma_request_out, dma_request_oe_out, input_ack_n_out, data_oe_out, rx_valid_out, burst_stop_out;
  logic host_ready_out, mdma_to_host_out, ack_n, req_on, slow = 0, hold = 0, seen_stop = 0;
  logic [1:0] e;
  logic [31:0] seed = 32'hE2215C5A;
  int mismatches = 0, total_checks = 0, rx_n = 0;
  always #2.5 core_clk_in = ~core_clk_in;
  assign pins_in = {pv[7:6], ack_n, pv[4:0]};
  assign req_on = dma_request_oe_out && (dma_request_out == (mode_strap_in == sdh_pkg::SDH_MODE_IDE));
  sdh_dma_io i_sdh_dma_io (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .mode_strap_in(mode_strap_in), .pins_in(pins_in), .data_pins_in(data_pins_in), .io_addr_hit_in(io_addr_hit_in),
    .io_read_data_in(io_read_data_in), .drive_selected_in(drive_selected_in), .xfer_pending_in(xfer_pending_in),
    .udma_active_in(udma_active_in), .udma_write_in(udma_write_in), .dma_request_out(dma_request_out),
    .dma_request_oe_out(dma_request_oe_out), .input_ack_n_out(input_ack_n_out), .data_out(data_out),
    .data_oe_out(data_oe_out), .rx_word_out(rx_word_out), .rx_valid_out(rx_valid_out),
    .burst_stop_out(burst_stop_out), .host_ready_out(host_ready_out), .mdma_to_host_out(mdma_to_host_out),
    .mode_out(mode_out));
  sdh_host_model i_sdh_host_model (.clk_in(core_clk_in), .req_on_in(req_on), .slow_in(slow), .hold_in(hold),
    .ack_n_out(ack_n), .acks_out(acks));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected {data drive, input ack level} for a read
  function logic [1:0] exp_io(input int m, input logic hit);
    return {m != 0, !(m == 1 && hit)};
  endfunction
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wt(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  // Link strobe at 64 ns period; data moves midway between edges
  task burst(input int n);
    for (int i = 0; i < n; i++) begin
      data_pins_in = 16'(rnd());
      wq.push_back(data_pins_in);
      #16 pv[3] = ~pv[3];
      #16;
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge core_clk_in) begin
    if (burst_stop_out === 1'h1) seen_stop = 1;
    if (rx_valid_out === 1'h1) begin
      rx_n++;
      chk(rx_word_out, wq.pop_front());
    end
  end
  initial begin
    #50000;
    mismatches++;
    end_of_test;
  end
  initial begin
    for (int m = 0; m < 3; m++) begin
      mode_strap_in = sdh_pkg::sdh_mode_t'(m);
      drive_selected_in = 1'(rnd());
      reset_n_in = 0;
      wt(3);
      reset_n_in = 1;
      wt(12);
      chk(mode_out, 16'(m));
      chk(dma_request_oe_out, m != 2 || drive_selected_in);
      chk(dma_request_out, m != 2);
      io_addr_hit_in = 1'(rnd());
      io_read_data_in = 16'(rnd());
      pv[7] = 0;
      pv[1] = 0;
      wt(8);
      e = exp_io(m, io_addr_hit_in);
      chk(data_oe_out, e[1]);
      chk(input_ack_n_out, e[0]);
      chk(data_out, e[1] ? io_read_data_in : 16'h0000);
      pv[7] = 1;
      pv[1] = 1;
      wt(8);
      chk(data_oe_out, 0);
      drive_selected_in = 1;
      slow = m[0];
      a0 = acks;
      wt(2);
      xfer_pending_in = 1;
      wt(1);
      chk(req_on, 1);
      wt(200);
      chk(acks - a0 > 8'h04, 1);
      xfer_pending_in = 0;
      wt(40);
      chk(req_on, 0);
      hold = 1;
      wt(8);
      pv[7] = 0;
      wt(8);
      chk(mdma_to_host_out, 1);
      pv[7] = 1;
      pv[6] = 0;
      wt(8);
      chk(mdma_to_host_out, 0);
      pv[6] = 1;
      udma_active_in = 1;
      udma_write_in = 1;
      wt(10);
      rx_n = 0;
      burst(6);
      wt(10);
      chk(rx_n, 6);
      wt(30);
      chk(rx_n, 6);
      burst(4);
      wt(10);
      chk(rx_n, 10);
      seen_stop = 0;
      pv[2] = 1;
      wt(10);
      chk(seen_stop, 1);
      pv[2] = 0;
      udma_write_in = 0;
      pv[4] = 0;
      wt(10);
      chk(host_ready_out, 1);
      ce_in = 0;
      pv[4] = 1;
      wt(10);
      chk(host_ready_out, 1);
      ce_in = 1;
      wt(10);
      chk(host_ready_out, 0);
      udma_active_in = 0;
      hold = 0;
      wt(10);
      $display("mode %0d test done", m);
    end
    end_of_test;
  end
endmodule
